//--- rtl/qpr_pkg.sv
/*
   Shared constants and types for the quadrature position readout:
   widths, reset values, the read-sequencer and inhibit state encodings,
   and the 4X gray-step decode.
   Assumes both ends import it; the carrier interface does not.
*/
package qpr_pkg;

   localparam int         CNT_WIDTH_DEFAULT = 16;
   localparam int         CNT_WIDTH_SHORT   = 12;
   localparam int         BYTE_W            = 8;
   localparam int         EXT_WIDTH_DEFAULT = 8;
   localparam int         SYNC_STAGES       = 2;
   localparam logic [7:0] LATCH_RESET_BYTE  = 8'h00;

   // inhibit sequencer in the device, sampled on falling clock edges
   typedef enum logic [2:0] {
      QPR_INH_IDLE  = 3'h1,
      QPR_INH_HOLD  = 3'h2,
      QPR_INH_ARMED = 3'h4
   } qpr_inh_state_t;

   // read sequencer in the host
   typedef enum logic [4:0] {
      QPR_RD_IDLE    = 5'h01,
      QPR_RD_HIGH    = 5'h02,
      QPR_RD_LOW     = 5'h04,
      QPR_RD_SINGLE  = 5'h08,
      QPR_RD_RELEASE = 5'h10
   } qpr_rd_state_t;

   // position of a phase pair along the gray cycle, phase A as the high bit
   function automatic logic [1:0] qpr_gray_index(input logic [1:0] ab);
      case (ab)
         2'h0:    qpr_gray_index = 2'h0;
         2'h2:    qpr_gray_index = 2'h1;
         2'h3:    qpr_gray_index = 2'h2;
         default: qpr_gray_index = 2'h3;
      endcase
   endfunction : qpr_gray_index

   // {count, up}: one step forward is up (A leads B), one step back is down
   function automatic logic [1:0] qpr_step(input logic [1:0] prevAb,
                                           input logic [1:0] curAb);
      logic [1:0] delta;
      delta = qpr_gray_index(curAb) - qpr_gray_index(prevAb);
      case (delta)
         2'h1:    qpr_step = 2'h3;
         2'h3:    qpr_step = 2'h2;
         default: qpr_step = 2'h0;
      endcase
   endfunction : qpr_step

endpackage : qpr_pkg

//--- rtl/qpr_if.sv
/*
   Carrier between the position readout device and its host.
   Holds the byte bus, its controls and the cascade/decoder outputs;
   resolves the data wire from the device's enable; a released bus
   reads as all ones, as a pulled-up bus would.
   Assumes both ends share sys_clk.
*/
interface qpr_if;
   logic       selHigh;
   logic       oeN;
   logic [7:0] dataOut;
   logic       dataOe;
   wire  [7:0] dataBus;
   logic       decodedCountPulse;
   logic       carryBorrowPulse;
   logic       countUp;

   assign dataBus = dataOe ? dataOut : 8'hFF;

   modport device (
      input  selHigh,
      input  oeN,
      output dataOut,
      output dataOe,
      output decodedCountPulse,
      output carryBorrowPulse,
      output countUp
   );

   modport host (
      output selHigh,
      output oeN,
      input  dataBus,
      input  decodedCountPulse,
      input  carryBorrowPulse,
      input  countUp
   );
endinterface : qpr_if

//--- rtl/qpr_device.sv
/*
   Device end of the quadrature position readout: phase decode, up/down
   position counter, position latch with read inhibit, byte multiplexer
   and decoded/cascade count pulses.
   Assumes phase inputs are already noise filtered but asynchronous, and
   that the host moves select and output enable on rising clock edges.
*/
module qpr_device #(
   parameter int CntWidth = qpr_pkg::CNT_WIDTH_DEFAULT
) (
   input  wire logic                sys_clk,
   input  wire logic                rstn,
   qpr_if.device                    bus,
   input  wire logic                phaseAInput,
   input  wire logic                phaseBInput,
   output logic     [CntWidth-1:0]  position,
   output logic                     inhibitActive
);
   import qpr_pkg::*;

   // elaboration check: the byte mux and wrap logic serve only these widths
   if (CntWidth != CNT_WIDTH_DEFAULT && CntWidth != CNT_WIDTH_SHORT) begin : g_badWidth
      $error("qpr_device: counter width must be 12 or 16");
   end

   logic [1:0]          phaseSync1_reg;
   logic [1:0]          phaseSync2_reg;
   logic [1:0]          phasePrev_reg;
   logic [1:0]          step;
   logic                countPend_reg;
   logic                dirPend_reg;
   logic                countUp_reg;
   logic [CntWidth-1:0] counter_reg;
   logic [CntWidth-1:0] counter_next;
   logic                wrap;
   logic [CntWidth-1:0] latch_reg;
   logic [15:0]         latchWide;
   logic                decRiseTgl_reg;
   logic                decFallTgl_reg;
   logic                casRiseTgl_reg;
   logic                casFallTgl_reg;
   qpr_inh_state_t      inhState_reg;
   qpr_inh_state_t      inhState_next;
   logic                inhibit;

   // phase pins are asynchronous: two flops before the decoder looks
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phaseSync1_reg <= 2'h0;
         phaseSync2_reg <= 2'h0;
      end else begin
         phaseSync1_reg <= {phaseAInput, phaseBInput};
         phaseSync2_reg <= phaseSync1_reg;
      end
   end

   // an illegal two-step jump is dropped rather than guessed at
   assign step = qpr_step(phasePrev_reg, phaseSync2_reg);

   // decode stage: direction is settled here, one edge ahead of the count
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phasePrev_reg <= 2'h0;
         countPend_reg <= 1'b0;
         dirPend_reg   <= 1'b1;
      end else begin
         phasePrev_reg <= phaseSync2_reg;
         countPend_reg <= step[1];
         if (step[1]) begin
            dirPend_reg <= step[0];
         end
      end
   end

   // direction output moves only with a new count, so it stays put for
   // a cycle after each pulse as long as steps are at least three cycles apart
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         countUp_reg <= 1'b1;
      end else if (step[1]) begin
         countUp_reg <= step[0];
      end
   end

   assign wrap = countPend_reg &&
                 (dirPend_reg ? (&counter_reg) : (counter_reg == '0));

   always_comb begin
      counter_next = counter_reg;
      if (countPend_reg) begin
         if (dirPend_reg) begin
            counter_next = counter_reg + 1'b1;
         end else begin
            counter_next = counter_reg - 1'b1;
         end
      end
   end

   // counter never looks at the inhibit: reads do not lose counts
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         counter_reg <= '0;
      end else begin
         counter_reg <= counter_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         latch_reg <= '0;
      end else if (!inhibit) begin
         latch_reg <= counter_reg;
      end
   end

   // half-period pulses: the rising edge toggles, the falling edge catches
   // up, so back-to-back counts still give separate pulses
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         decRiseTgl_reg <= 1'b0;
         casRiseTgl_reg <= 1'b0;
      end else begin
         if (countPend_reg) begin
            decRiseTgl_reg <= ~decRiseTgl_reg;
         end
         if (wrap) begin
            casRiseTgl_reg <= ~casRiseTgl_reg;
         end
      end
   end

   always_ff @(negedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         decFallTgl_reg <= 1'b0;
         casFallTgl_reg <= 1'b0;
      end else begin
         decFallTgl_reg <= decRiseTgl_reg;
         casFallTgl_reg <= casRiseTgl_reg;
      end
   end

   assign bus.decodedCountPulse = decRiseTgl_reg ^ decFallTgl_reg;
   assign bus.carryBorrowPulse  = casRiseTgl_reg ^ casFallTgl_reg;
   assign bus.countUp           = countUp_reg;

   always_comb begin
      inhState_next = inhState_reg;
      case (inhState_reg)
         QPR_INH_IDLE: begin
            if (!bus.oeN && !bus.selHigh) begin
               inhState_next = QPR_INH_HOLD;
            end
         end
         QPR_INH_HOLD: begin
            if (!bus.oeN && bus.selHigh) begin
               inhState_next = QPR_INH_ARMED;
            end
         end
         QPR_INH_ARMED: begin
            if (bus.oeN) begin
               inhState_next = QPR_INH_IDLE;
            end
         end
         default: begin
            inhState_next = QPR_INH_IDLE;
         end
      endcase
   end

   // falling-edge sampling gives the host half a cycle of setup after it
   // moves the controls on the rising edge
   always_ff @(negedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         inhState_reg <= QPR_INH_IDLE;
      end else begin
         inhState_reg <= inhState_next;
      end
   end

   assign inhibit = (inhState_reg != QPR_INH_IDLE);

   assign latchWide = 16'(latch_reg);

   // the mux itself is open whenever the bus is enabled; the inhibit only
   // freezes what it shows
   assign bus.dataOut = bus.selHigh ? latchWide[7:0] : latchWide[15:8];
   assign bus.dataOe  = !bus.oeN;

   assign position      = counter_reg;
   assign inhibitActive = inhibit;

endmodule : qpr_device

//--- rtl/qpr_host.sv
/*
   Host end of the quadrature position readout: two-byte or single-byte
   reads over the byte bus, plus an external cascade counter that is
   latched when a two-byte read starts.
   Assumes the device shares sys_clk; all link signals are same-domain.
*/
module qpr_host #(
   parameter int ExtWidth = qpr_pkg::EXT_WIDTH_DEFAULT
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   qpr_if.host                       bus,
   input  wire logic                 readStart,
   input  wire logic                 byteMode,
   output logic                      readBusy,
   output logic                      readDone,
   output logic     [ExtWidth+15:0]  readData
);
   import qpr_pkg::*;

   // elaboration check on the cascade counter width
   if (ExtWidth < 1 || ExtWidth > 32) begin : g_badWidth
      $error("qpr_host: cascade width must be 1 to 32");
   end

   qpr_rd_state_t       rdState_reg;
   logic                selHigh_reg;
   logic                oeN_reg;
   logic                readDone_reg;
   logic [ExtWidth-1:0] extCount_reg;
   logic [ExtWidth-1:0] extLatch_reg;
   logic [7:0]          hiByte_reg;
   logic [7:0]          loByte_reg;

   // the cascade pulse is high from rising to falling edge, so sampling
   // on the falling edge counts each pulse exactly once
   always_ff @(negedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         extCount_reg <= '0;
      end else if (bus.carryBorrowPulse) begin
         if (bus.countUp) begin
            extCount_reg <= extCount_reg + 1'b1;
         end else begin
            extCount_reg <= extCount_reg - 1'b1;
         end
      end
   end

   // controls change only on rising edges to meet falling-edge sampling
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdState_reg  <= QPR_RD_IDLE;
         selHigh_reg  <= 1'b1;
         oeN_reg      <= 1'b1;
         readDone_reg <= 1'b0;
         extLatch_reg <= '0;
         hiByte_reg   <= LATCH_RESET_BYTE;
         loByte_reg   <= LATCH_RESET_BYTE;
      end else begin
         readDone_reg <= 1'b0;
         case (rdState_reg)
            QPR_RD_IDLE: begin
               selHigh_reg <= byteMode;
               if (readStart && byteMode) begin
                  oeN_reg     <= 1'b0;
                  rdState_reg <= QPR_RD_SINGLE;
               end else if (readStart) begin
                  selHigh_reg  <= 1'b0;
                  oeN_reg      <= 1'b0;
                  extLatch_reg <= extCount_reg;
                  rdState_reg  <= QPR_RD_HIGH;
               end
            end
            QPR_RD_HIGH: begin
               hiByte_reg  <= bus.dataBus;
               selHigh_reg <= 1'b1;
               rdState_reg <= QPR_RD_LOW;
            end
            QPR_RD_LOW: begin
               loByte_reg  <= bus.dataBus;
               oeN_reg     <= 1'b1;
               rdState_reg <= QPR_RD_RELEASE;
            end
            QPR_RD_SINGLE: begin
               hiByte_reg  <= LATCH_RESET_BYTE;
               loByte_reg  <= bus.dataBus;
               oeN_reg     <= 1'b1;
               rdState_reg <= QPR_RD_RELEASE;
            end
            QPR_RD_RELEASE: begin
               readDone_reg <= 1'b1;
               rdState_reg  <= QPR_RD_IDLE;
            end
            default: begin
               oeN_reg     <= 1'b1;
               rdState_reg <= QPR_RD_IDLE;
            end
         endcase
      end
   end

   assign bus.selHigh = selHigh_reg;
   assign bus.oeN     = oeN_reg;
   assign readBusy    = (rdState_reg != QPR_RD_IDLE);
   assign readDone    = readDone_reg;
   assign readData    = {extLatch_reg, hiByte_reg, loByte_reg};

endmodule : qpr_host

//--- tb/qpr_props.sv
/* assertions on the readout link between the device and host ends.
   assumes one sys_clk domain and an async active-low rstn. */
module qpr_props (
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic       selHigh,
   input wire logic       oeN,
   input wire logic [7:0] dataOut,
   input wire logic       dataOe,
   input wire logic [7:0] dataBus,
   input wire logic       decodedCountPulse,
   input wire logic       carryBorrowPulse,
   input wire logic       countUp
);
   timeunit 1ns;
   timeprecision 1ns;
   sequence s_hiRead;
      !oeN && !selHigh;
   endsequence
   sequence s_loRead;
      !oeN && selHigh;
   endsequence
   property p_order;
      @(posedge sys_clk) disable iff (!rstn)
         $fell(oeN) && !selHigh |-> s_hiRead ##1 s_loRead ##1 oeN;
   endproperty
   a_order: assert property (p_order)
      else $error("two-byte read out of order");
   property p_byte;
      @(posedge sys_clk) disable iff (!rstn)
         $fell(oeN) && selHigh |-> s_loRead ##1 (oeN && selHigh);
   endproperty
   a_byte: assert property (p_byte)
      else $error("single-byte read malformed");
   property p_selLow;
      @(posedge sys_clk) disable iff (!rstn) !oeN && !selHigh |=> !oeN && selHigh;
   endproperty
   a_selLow: assert property (p_selLow)
      else $error("high byte not followed by low byte");
   property p_oe;
      @(posedge sys_clk) disable iff (!rstn) dataOe == !oeN;
   endproperty
   a_oe: assert property (p_oe)
      else $error("bus drive does not follow output enable");
   property p_bus;
      @(posedge sys_clk) disable iff (!rstn) dataOe |-> dataBus == dataOut;
   endproperty
   a_bus: assert property (p_bus)
      else $error("bus differs from mux output");
   // sampled just before a rising edge a half-period pulse is always low
   property p_dcHalf;
      @(posedge sys_clk) disable iff (!rstn) !decodedCountPulse;
   endproperty
   a_dcHalf: assert property (p_dcHalf)
      else $error("count pulse longer than half a period");
   property p_cbHalf;
      @(posedge sys_clk) disable iff (!rstn) !carryBorrowPulse;
   endproperty
   a_cbHalf: assert property (p_cbHalf)
      else $error("cascade pulse longer than half a period");
   property p_cbDc;
      @(negedge sys_clk) disable iff (!rstn) carryBorrowPulse |-> decodedCountPulse;
   endproperty
   a_cbDc: assert property (p_cbDc)
      else $error("cascade pulse without a count");
   property p_dir;
      @(negedge sys_clk) disable iff (!rstn)
         decodedCountPulse || carryBorrowPulse |-> $stable(countUp) ##1 $stable(countUp);
   endproperty
   a_dir: assert property (p_dir)
      else $error("direction moved around a pulse");
endmodule : qpr_props

//--- tb/qpr_tb_top.sv
/* readout bench: 16-bit and 12-bit device/host pairs share the phase
   pins and read controls; the checker watches the 16-bit link.
   assumes hosts take readStart only while idle. */
module qpr_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qpr_pkg::*;
   typedef struct packed {
      logic        mode;
      logic        inh;
      logic [23:0] d16;
      logic [23:0] d12;
   } qpr_exp_t;
   logic        sys_clk     = 1'b0;
   logic        rstn        = 1'b0;
   logic        phaseAInput = 1'b0;
   logic        phaseBInput = 1'b0;
   logic        readStart   = 1'b0;
   logic        byteMode    = 1'b0;
   logic        inhSeen     = 1'b0;
   logic [1:0]  idx         = 2'h0;
   logic [15:0] pos16;
   logic [11:0] pos12;
   logic        inh16;
   logic        inh12;
   logic        done16;
   logic        done12;
   logic [23:0] rd16;
   logic [23:0] rd12;
   int          err_count   = 0;
   int          comparisons = 0;
   int          seed        = 32'h19B68FFA;
   int          total       = 0;
   int          carries     = 0;
   int          cbSeen      = 0;
   int          v;
   qpr_exp_t    expQ[$];
   logic        dirQ[$];
   qpr_if qpr_if_i ();
   qpr_if qpr_if12_i ();
   qpr_device #(.CntWidth(16)) qpr_device_i (.sys_clk(sys_clk), .rstn(rstn),
      .bus(qpr_if_i.device), .phaseAInput(phaseAInput), .phaseBInput(phaseBInput),
      .position(pos16), .inhibitActive(inh16));
   qpr_device #(.CntWidth(12)) qpr_device_short_i (.sys_clk(sys_clk), .rstn(rstn),
      .bus(qpr_if12_i.device), .phaseAInput(phaseAInput), .phaseBInput(phaseBInput),
      .position(pos12), .inhibitActive(inh12));
   qpr_host qpr_host_i (.sys_clk(sys_clk), .rstn(rstn), .bus(qpr_if_i.host),
      .readStart(readStart), .byteMode(byteMode), .readBusy(), .readDone(done16),
      .readData(rd16));
   qpr_host qpr_host_short_i (.sys_clk(sys_clk), .rstn(rstn), .bus(qpr_if12_i.host),
      .readStart(readStart), .byteMode(byteMode), .readBusy(), .readDone(done12),
      .readData(rd12));
   qpr_props qpr_props_i (.sys_clk(sys_clk), .rstn(rstn), .selHigh(qpr_if_i.selHigh),
      .oeN(qpr_if_i.oeN), .dataOut(qpr_if_i.dataOut), .dataOe(qpr_if_i.dataOe),
      .dataBus(qpr_if_i.dataBus), .decodedCountPulse(qpr_if_i.decodedCountPulse),
      .carryBorrowPulse(qpr_if_i.carryBorrowPulse), .countUp(qpr_if_i.countUp));
   always #50 sys_clk = ~sys_clk;
   task automatic check_data(input string what, input logic [23:0] ex, input logic [23:0] got);
      comparisons++;
      if (got !== ex) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, ex, got);
      end
   endtask : check_data
   task automatic check_bit(input string what, input logic ex, input logic got);
      comparisons++;
      if (got !== ex) begin
         err_count++;
         $display("mismatch %s expected %b seen %b", what, ex, got);
      end
   endtask : check_bit
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   // gaps of three or more keep the direction steady past each pulse
   task automatic step(input logic up, input int gap);
      idx = up ? idx + 2'h1 : idx - 2'h1;
      dirQ.push_back(up);
      total = total + (up ? 1 : -1);
      if (total[15:0] == (up ? 16'h0 : 16'hFFFF)) carries++;
      {phaseAInput, phaseBInput} <= {idx[1] ^ idx[0], idx[1]};
      repeat (gap) @(posedge sys_clk);
   endtask : step
   task automatic do_read(input logic bm, input int ex);
      qpr_exp_t e;
      e.mode = bm;
      e.inh = ~bm;
      e.d16 = ex[23:0];
      e.d12 = {ex[19:12], 4'h0, ex[11:0]};
      expQ.push_back(e);
      // a spare edge lets a step made just before the call reach the latch
      @(posedge sys_clk);
      byteMode <= bm;
      readStart <= 1'b1;
      @(posedge sys_clk);
      readStart <= 1'b0;
      for (int i = 0; i < 12 && done16 !== 1'b1; i++) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask : do_read
   always @(negedge sys_clk) begin : monitor
      qpr_exp_t e;
      if (inh16 !== 1'b0 || inh12 !== 1'b0) inhSeen = 1'b1;
      if (qpr_if_i.carryBorrowPulse === 1'b1) cbSeen++;
      if (qpr_if_i.decodedCountPulse === 1'b1) begin
         check_bit("direction", dirQ.size() ? dirQ.pop_front() : 1'bx, qpr_if_i.countUp);
      end
      if (done16 === 1'b1 && expQ.size() > 0) begin
         e = expQ.pop_front();
         check_bit("inhibit seen", e.inh, inhSeen);
         check_bit("done12", 1'b1, done12);
         check_bit("bus drive", 1'b0, qpr_if_i.dataOe);
         check_data("read16", e.mode ? 24'(e.d16[7:0]) : e.d16,
                    e.mode ? 24'(rd16[7:0]) : rd16);
         check_data("read12", e.mode ? 24'(e.d12[7:0]) : e.d12,
                    e.mode ? 24'(rd12[7:0]) : rd12);
         inhSeen = 1'b0;
      end
   end
   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      do_read(1'b0, 0);
      repeat (3) step(1'b0, 3);
      do_read(1'b0, total);
      repeat (3) step(1'b1, 3);
      do_read(1'b1, total);
      for (int n = 0; n < 300; n++) begin
         step(1'($random(seed)), 3 + ($random(seed) & 3));
         if (n % 30 == 29) do_read(1'($random(seed)), total);
      end
      // this count reaches the counter just after the inhibit is set
      v = total;
      step(1'b1, 1);
      do_read(1'b0, v);
      check_data("position", 24'(total[15:0]), 24'(pos16));
      check_data("position12", 24'(total[11:0]), 24'(pos12));
      // back to phase state zero so the reset synchronizer sees no jump
      while (idx != 2'h0) step(1'b1, 3);
      repeat (4) @(posedge sys_clk);
      readStart <= 1'b1;
      byteMode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      readStart <= 1'b0;
      #20 rstn = 1'b0;
      #10 check_bit("inhibit", 1'b0, inh16 | inh12);
      check_data("position", 24'h0, 24'(pos16));
      inhSeen = 1'b0;
      total = 0;
      @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      do_read(1'b0, 0);
      check_data("cascade count", 24'(carries), 24'(cbSeen));
      check_data("pending", 24'h0, 24'(expQ.size() + dirQ.size()));
      wrap_up();
   end
endmodule : qpr_tb_top
